// file: core/sesr_top.sv
// status registers, error queue and self-test sequencer of the instrument
// assumes a same-clock register master and a same-clock test engine;
// condition inputs are asynchronous levels and pass two flip-flops.
`timescale 1ns/10ps
`include "sesr_regs.svh"
module sesr_top #(
  parameter int NBITS = 16,
  parameter int DEPTH = `SESR_ERR_DEPTH,
  parameter int NTEST = 94
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic cal_active,
  input wire logic wait_trig,
  input wire logic pretrig_met,
  input wire logic meas_done,
  input wire logic [NBITS-1:0] ques_cond_in,
  input wire logic err_push,
  input wire logic signed [15:0] err_num,
  input wire logic [15:0] err_msg,
  input wire logic [6:0] tst_done_num,
  input wire logic tst_done,
  input wire logic tst_fail,
  input wire logic [7:0] tst_code,
  input wire logic [15:0] tst_detail,
  output logic [7:0] status_byte,
  output logic tst_start,
  output logic [6:0] tst_num,
  output logic tst_busy
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NBITS-1:0] opc_m;
    logic [NBITS-1:0] opc;
    logic [NBITS-1:0] opc_d;
    logic [NBITS-1:0] ope;
    logic [NBITS-1:0] open_;
    logic [NBITS-1:0] qc_m;
    logic [NBITS-1:0] qc;
    logic [NBITS-1:0] qc_d;
    logic [NBITS-1:0] qe;
    logic [NBITS-1:0] qen;
    logic [7:0] stb;
    logic [PW-1:0] rp;
    logic [PW-1:0] wp;
    logic [CW-1:0] cnt;
    logic ovf;
    logic [31:0] rdata;
    sesr_pkg::sesr_test_e st;
    logic repeat_mode;
    logic [6:0] cur;
    logic [14:0] left;
    logic [14:0] fails;
    logic [6:0] first;
    logic start;
  } sesr_state_s;
  sesr_state_s s_ff;
  sesr_state_s nxt_s;
  sesr_pkg::sesr_err_s q_mem [DEPTH];
  logic [7:0] code_mem [NTEST+1];
  logic [15:0] det_mem [NTEST+1];
  logic [NTEST:0] fail_vec;
  logic [NBITS-1:0] opc_raw;
  logic [6:0] sel_tst;
  logic do_push;
  logic do_pop;
  logic do_ovw;
  logic sw_cls;

  // operational condition pins in their fixed slots
  always_comb begin
    opc_raw = '0;
    opc_raw[`SESR_OPC_CAL] = cal_active;
    opc_raw[`SESR_OPC_WTRIG] = wait_trig;
    opc_raw[`SESR_OPC_PRETRIG] = pretrig_met;
    opc_raw[`SESR_OPC_MDONE] = meas_done;
  end

  assign sel_tst = wdata[6:0];
  assign sw_cls = wr && addr == `SESR_CONTROL && wdata[`SESR_CTL_CLS];
  assign do_pop = rd && addr == `SESR_ERR_READ && s_ff.cnt != '0;
  // a push that lands on a full queue turns into one overwrite, then stays shut until a pop or a clear
  assign do_push = err_push && !s_ff.ovf && (s_ff.cnt != CW'(DEPTH) || do_pop);
  assign do_ovw = err_push && !s_ff.ovf && s_ff.cnt == CW'(DEPTH) && !do_pop;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.start = 1'b0;
    nxt_s.rdata = 32'h0000_0000;
    // two flip-flop synchronisers, delayed copy for edge detect
    nxt_s.opc_m = opc_raw;
    nxt_s.opc = s_ff.opc_m;
    nxt_s.opc_d = s_ff.opc;
    nxt_s.qc_m = ques_cond_in;
    nxt_s.qc = s_ff.qc_m;
    nxt_s.qc_d = s_ff.qc;
    // read side effects first, so a same-cycle edge still sets
    if (rd && addr == `SESR_OPER_EVENT) begin
      nxt_s.ope = '0;
    end
    if (rd && addr == `SESR_QUES_EVENT) begin
      nxt_s.qe = '0;
    end
    if (sw_cls) begin
      nxt_s.ope = '0;
      nxt_s.qe = '0;
    end
    // set wins over clear on every event bit
    nxt_s.ope = nxt_s.ope | (s_ff.opc & ~s_ff.opc_d);
    nxt_s.qe = nxt_s.qe | (s_ff.qc & ~s_ff.qc_d);
    // summary bits, masked events ignored
    nxt_s.stb[`SESR_STB_OPER] = |(s_ff.ope & s_ff.open_);
    nxt_s.stb[`SESR_STB_QUES] = |(s_ff.qe & s_ff.qen);
    // register writes
    if (wr) begin
      unique case (addr)
        `SESR_OPER_ENABLE: nxt_s.open_ = wdata[NBITS-1:0];
        `SESR_QUES_ENABLE: nxt_s.qen = wdata[NBITS-1:0];
        `SESR_CONTROL: begin
          if (wdata[`SESR_CTL_PRESET]) begin
            nxt_s.open_ = '0;
            nxt_s.qen = '0;
          end
        end
        `SESR_TEST_CMD: begin
          // full suite when cycles field is zero, else repeat one test
          if (s_ff.st == sesr_pkg::SESR_IDLE) begin
            if (wdata[30:16] == 15'h0000) begin
              nxt_s.repeat_mode = 1'b0;
              nxt_s.cur = `SESR_TEST_MIN;
              nxt_s.first = 7'h00;
              nxt_s.fails = '0;
              nxt_s.st = sesr_pkg::SESR_RUN;
            end else if (sel_tst >= `SESR_TEST_MIN && sel_tst <= `SESR_TEST_MAX) begin
              nxt_s.repeat_mode = 1'b1;
              nxt_s.cur = sel_tst;
              nxt_s.left = wdata[30:16];
              nxt_s.fails = '0;
              nxt_s.st = sesr_pkg::SESR_RUN;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // queue pointers and count
    if (sw_cls) begin
      nxt_s.rp = '0;
      nxt_s.wp = '0;
      nxt_s.cnt = '0;
      nxt_s.ovf = 1'b0;
    end else begin
      if (do_pop) begin
        nxt_s.rp = (s_ff.rp == PW'(DEPTH - 1)) ? '0 : s_ff.rp + 1'b1;
        nxt_s.ovf = 1'b0;
      end
      if (do_push) begin
        nxt_s.wp = (s_ff.wp == PW'(DEPTH - 1)) ? '0 : s_ff.wp + 1'b1;
      end
      if (do_ovw) begin
        nxt_s.ovf = 1'b1;
      end
      nxt_s.cnt = s_ff.cnt + CW'(do_push) - CW'(do_pop);
    end
    // register reads, data one cycle later
    if (rd) begin
      unique case (addr)
        `SESR_OPER_COND: nxt_s.rdata = 32'(s_ff.opc);
        `SESR_OPER_EVENT: nxt_s.rdata = 32'(s_ff.ope);
        `SESR_OPER_ENABLE: nxt_s.rdata = 32'(s_ff.open_);
        `SESR_QUES_COND: nxt_s.rdata = 32'(s_ff.qc);
        `SESR_QUES_EVENT: nxt_s.rdata = 32'(s_ff.qe);
        `SESR_QUES_ENABLE: nxt_s.rdata = 32'(s_ff.qen);
        `SESR_STATUS_BYTE: nxt_s.rdata = {24'h00_0000, s_ff.stb};
        `SESR_ERR_READ: begin
          if (s_ff.cnt == '0) begin
            nxt_s.rdata = {`SESR_ERR_NONE, `SESR_MSG_NONE};
          end else begin
            nxt_s.rdata = {q_mem[s_ff.rp].num, q_mem[s_ff.rp].msg};
          end
        end
        `SESR_ERR_COUNT: nxt_s.rdata = 32'(s_ff.cnt);
        `SESR_VERSION: nxt_s.rdata = {12'h000, `SESR_VER_YEAR, `SESR_VER_REV};
        `SESR_TEST_STAT: nxt_s.rdata = {s_ff.fails, 16'h0000, s_ff.st != sesr_pkg::SESR_IDLE};
        `SESR_TEST_FIRST: nxt_s.rdata = 32'(s_ff.first);
        `SESR_TEST_CODE: nxt_s.rdata = (sel_tst <= `SESR_TEST_MAX) ? 32'(code_mem[sel_tst]) : '0;
        `SESR_TEST_DETAIL: nxt_s.rdata = (sel_tst <= `SESR_TEST_MAX) ? 32'(det_mem[sel_tst]) : '0;
        `SESR_FAIL_LIST: begin
          // one word per 32 tests; word chosen by wdata[1:0]
          unique case (wdata[1:0])
            2'd0: nxt_s.rdata = fail_vec[31:0];
            2'd1: nxt_s.rdata = fail_vec[63:32];
            2'd2: nxt_s.rdata = {1'b0, fail_vec[94:64]};
            default: nxt_s.rdata = 32'h0000_0000;
          endcase
        end
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    // self-test sequencer: one test handed out, result awaited
    unique case (s_ff.st)
      sesr_pkg::SESR_IDLE: begin
      end
      sesr_pkg::SESR_RUN: begin
        nxt_s.start = 1'b1;
        nxt_s.st = sesr_pkg::SESR_WAIT;
      end
      sesr_pkg::SESR_WAIT: begin
        if (tst_done) begin
          if (s_ff.repeat_mode) begin
            nxt_s.fails = s_ff.fails + 15'(tst_fail);
            nxt_s.left = s_ff.left - 1'b1;
            nxt_s.st = (s_ff.left == 15'h0001) ? sesr_pkg::SESR_IDLE : sesr_pkg::SESR_RUN;
          end else begin
            if (tst_fail && s_ff.first == 7'h00) begin
              nxt_s.first = s_ff.cur;
            end
            nxt_s.cur = s_ff.cur + 1'b1;
            nxt_s.st = (s_ff.cur == `SESR_TEST_MAX) ? sesr_pkg::SESR_IDLE : sesr_pkg::SESR_RUN;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // queue storage, no reset needed behind the count
  always_ff @(posedge clk) begin
    if (do_push) begin
      q_mem[s_ff.wp] <= '{num: err_num, msg: err_msg};
    end
    if (do_ovw) begin
      q_mem[(s_ff.wp == '0) ? PW'(DEPTH - 1) : s_ff.wp - 1'b1] <= '{num: `SESR_ERR_OVERFLOW,
        msg: `SESR_MSG_OVERFLOW};
    end
  end

  // per-test result store, one entry per test number
  genvar gi;
  generate
    for (gi = 0; gi <= NTEST; gi++) begin : g_res
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          code_mem[gi] <= 8'h00;
          det_mem[gi] <= 16'h0000;
          fail_vec[gi] <= 1'b0;
        end else if (s_ff.st == sesr_pkg::SESR_WAIT && tst_done && tst_done_num == 7'(gi)) begin
          code_mem[gi] <= tst_code;
          det_mem[gi] <= tst_detail;
          fail_vec[gi] <= tst_fail && gi != 0;
        end
      end
    end
  endgenerate

  assign rdata = s_ff.rdata;
  assign status_byte = s_ff.stb;
  assign tst_start = s_ff.start;
  assign tst_num = s_ff.cur;
  assign tst_busy = s_ff.st != sesr_pkg::SESR_IDLE;
endmodule

// file: core/sesr_regs.svh
// register offsets, field positions, limits and codes of the status block
// assumes a word-wide plain register port, one register per index
`ifndef SESR_REGS_SVH
`define SESR_REGS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SESR_OPER_COND 8'h00
`define SESR_OPER_EVENT 8'h01
`define SESR_OPER_ENABLE 8'h02
`define SESR_QUES_COND 8'h03
`define SESR_QUES_EVENT 8'h04
`define SESR_QUES_ENABLE 8'h05
`define SESR_STATUS_BYTE 8'h06
`define SESR_CONTROL 8'h07
`define SESR_ERR_READ 8'h08
`define SESR_ERR_COUNT 8'h09
`define SESR_VERSION 8'h0a
`define SESR_TEST_CMD 8'h0b
`define SESR_TEST_STAT 8'h0c
`define SESR_TEST_FIRST 8'h0d
`define SESR_TEST_CODE 8'h0e
`define SESR_TEST_DETAIL 8'h0f
`define SESR_FAIL_LIST 8'h10
// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define SESR_CTL_PRESET 0
`define SESR_CTL_CLS 1
`define SESR_STB_QUES 3
`define SESR_STB_OPER 7
`define SESR_OPC_CAL 0
`define SESR_OPC_WTRIG 5
`define SESR_OPC_PRETRIG 8
`define SESR_OPC_MDONE 9
`define SESR_ERR_DEPTH 20
`define SESR_ERR_NONE 16'sh0000
`define SESR_ERR_OVERFLOW (-16'sd350)
`define SESR_MSG_NONE 16'h0000
`define SESR_MSG_OVERFLOW 16'h015e
`define SESR_TEST_MIN 7'h01
`define SESR_TEST_MAX 7'h5e
`define SESR_TEST_REGRW 7'h01
`define SESR_TEST_CALROM 7'h02
`define SESR_TEST_NOISE0 7'h03
`define SESR_CYC_MAX 15'h7fff
`define SESR_VER_YEAR 16'h07d0
`define SESR_VER_REV 4'h0
`endif

// file: core/sesr_pkg.sv
// types shared by the status, error queue and self-test block
// assumes sesr_regs.svh supplies the numeric constants
package sesr_pkg;
  typedef enum logic [1:0] {
    SESR_IDLE,
    SESR_RUN,
    SESR_WAIT
  } sesr_test_e;
  typedef struct packed {
    logic signed [15:0] num;
    logic [15:0] msg;
  } sesr_err_s;
endpackage

// file: sim/sesr_engine.sv
// test engine model: answers each test start with one done pulse
// assumes the block's clock and reset; results stand in the done cycle only
`timescale 1ns/10ps
module sesr_engine #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tst_start,
  input wire logic [6:0] tst_num,
  input wire logic [6:0] fail_num,
  output logic tst_done,
  output logic [6:0] tst_done_num,
  output logic tst_fail,
  output logic [7:0] tst_code,
  output logic [15:0] tst_detail
);
  logic [3:0] cnt_ff;
  logic [6:0] num_ff;
  // one run per start, a fixed latency
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 4'h0;
      num_ff <= 7'h00;
    end else if (tst_start) begin
      cnt_ff <= 4'(LAT);
      num_ff <= tst_num;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  // results inverted outside the done cycle so stale values never match
  assign tst_done = cnt_ff == 4'h1;
  assign tst_done_num = tst_done ? num_ff : ~num_ff;
  assign tst_fail = tst_done ? num_ff == fail_num : num_ff != fail_num;
  assign tst_code = tst_done ? {1'b0, num_ff} : {1'b1, ~num_ff};
  assign tst_detail = tst_done ? {9'h000, num_ff} : {9'h1ff, ~num_ff};
endmodule

// file: sim/sesr_checker.sv
// port checker of the status block
// assumes a bind onto sesr_top, one clock domain
`timescale 1ns/10ps
`include "sesr_regs.svh"
module sesr_checker #(
  parameter int NBITS = 16,
  parameter int NTEST = 94
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [NBITS-1:0] ques_cond_in,
  input wire logic [7:0] status_byte,
  input wire logic tst_start,
  input wire logic [6:0] tst_num,
  input wire logic tst_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------
  // assertions
  // ----------------
  a_stb_spare: assert property (status_byte[6:4] == 3'h0 && status_byte[2:0] == 3'h0)
    else $error("status byte spare bit set");
  a_ver_read: assert property (rd && addr == `SESR_VERSION |=> rdata == {12'h000, `SESR_VER_YEAR, `SESR_VER_REV})
    else $error("version word wrong");
  a_start_busy: assert property (tst_start |-> tst_busy)
    else $error("start while idle");
  a_cmd_start: assert property (wr && addr == `SESR_TEST_CMD && wdata[6:0] >= 1 && wdata[6:0] <= NTEST
    && wdata[30:16] != 15'h0000 && !tst_busy |=> tst_busy ##1 (tst_start && tst_num == $past(wdata[6:0], 2)))
    else $error("repeat command did not start its test");
  a_bad_test: assert property (wr && addr == `SESR_TEST_CMD && wdata[6:0] > NTEST && wdata[30:16] != 15'h0000
    && !tst_busy |=> !tst_busy)
    else $error("out of range test accepted");
  a_preset_mask: assert property (wr && addr == `SESR_CONTROL && wdata[0] ##2 rd && addr == `SESR_QUES_ENABLE
    |=> rdata == 32'h0000_0000)
    else $error("preset left mask bits");
  a_mask_summ: assert property ($past(rd && addr == `SESR_QUES_ENABLE) && rdata == 32'h0000_0000 |=> !status_byte[3])
    else $error("masked event reached summary");
  // stable conditions mean no new edge, so a second read finds nothing
  a_rd_clear: assert property ($stable(ques_cond_in)[*5] ##0 (rd && addr == `SESR_QUES_EVENT)
    ##2 (rd && addr == `SESR_QUES_EVENT) |=> rdata == 32'h0000_0000)
    else $error("event read did not clear");
  c_summary: cover property (status_byte[3] && status_byte[7]);
  c_start: cover property (tst_start);
  c_overflow: cover property (rdata == {`SESR_ERR_OVERFLOW, `SESR_MSG_OVERFLOW});
endmodule

// file: sim/sesr_top_tb.sv
// self-checking bench of the status, error queue and self-test block
// assumes sesr_top, sesr_engine and sesr_checker compiled before it
`timescale 1ns/10ps
`include "sesr_regs.svh"
module sesr_top_tb;
  logic clk, reset, wr, rd, err_push, tst_start, tst_busy, tst_done, tst_fail;
  logic cal_active, wait_trig, pretrig_met, meas_done;
  logic [7:0] addr, status_byte, tst_code;
  logic [31:0] wdata, rdata, d;
  logic [15:0] ques_cond_in, err_msg, tst_detail;
  logic signed [15:0] err_num;
  logic [6:0] tst_num, tst_done_num, fail_num;
  int err_total, tests_run, wd_cnt;
  sesr_top i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cal_active(cal_active), .wait_trig(wait_trig), .pretrig_met(pretrig_met), .meas_done(meas_done),
    .ques_cond_in(ques_cond_in), .err_push(err_push), .err_num(err_num), .err_msg(err_msg),
    .tst_done_num(tst_done_num), .tst_done(tst_done), .tst_fail(tst_fail), .tst_code(tst_code),
    .tst_detail(tst_detail), .status_byte(status_byte), .tst_start(tst_start), .tst_num(tst_num), .tst_busy(tst_busy));
  sesr_engine i_eng (.clk(clk), .reset(reset), .tst_start(tst_start), .tst_num(tst_num), .fail_num(fail_num),
    .tst_done(tst_done), .tst_done_num(tst_done_num), .tst_fail(tst_fail), .tst_code(tst_code), .tst_detail(tst_detail));
  // ----------------
  // helpers
  // ----------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // one strobe cycle; read data lands one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic push(input int n);
    for (int k = 1; k <= n; k++) begin
      @(posedge clk);
      err_push <= 1'b1;
      err_num <= 16'(k);
      err_msg <= 16'(k);
    end
    @(posedge clk);
    err_push <= 1'b0;
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge clk);
    while (tst_busy !== 1'b0) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // clock and hang guard, far above the several hundred cycles needed
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    wd_cnt++;
    if (wd_cnt == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    reset = 1'b1;
    {wr, rd, err_push, cal_active, wait_trig, pretrig_met, meas_done} = 7'h00;
    {addr, wdata, ques_cond_in, err_num, err_msg, fail_num} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    acc(0, `SESR_VERSION, 0); chk("version", d, {12'h000, `SESR_VER_YEAR, `SESR_VER_REV});
    acc(0, 8'h20, 0); chk("unmapped", d, 0);
    acc(1, `SESR_QUES_ENABLE, 32'h0000_00ff);
    ques_cond_in <= 16'h0005;
    repeat (6) @(posedge clk);
    acc(0, `SESR_QUES_COND, 0); chk("ques cond", d, 32'h0000_0005);
    chk("ques summary", status_byte[3], 1);
    acc(0, `SESR_QUES_ENABLE, 0); chk("ques enable", d, 32'h0000_00ff);
    acc(0, `SESR_QUES_ENABLE, 0); chk("enable reread", d, 32'h0000_00ff);
    acc(0, `SESR_QUES_EVENT, 0); chk("ques event", d, 32'h0000_0005);
    acc(0, `SESR_QUES_EVENT, 0); chk("event cleared", d, 0);
    ques_cond_in <= 16'h0105;
    repeat (6) @(posedge clk);
    acc(0, `SESR_STATUS_BYTE, 0); chk("masked summary", d[3], 0);
    acc(1, `SESR_CONTROL, 32'h0000_0001);
    acc(0, `SESR_QUES_ENABLE, 0); chk("preset enable", d, 0);
    acc(0, `SESR_QUES_EVENT, 0); chk("event kept", d, 32'h0000_0100);
    acc(1, `SESR_OPER_ENABLE, 32'h0000_0200);
    {cal_active, wait_trig, pretrig_met, meas_done} <= 4'hf;
    repeat (6) @(posedge clk);
    acc(0, `SESR_OPER_COND, 0); chk("oper cond", d, 32'h0000_0321);
    chk("oper summary", status_byte[7], 1);
    acc(0, `SESR_OPER_EVENT, 0); chk("oper event", d, 32'h0000_0321);
    acc(0, `SESR_STATUS_BYTE, 0); chk("oper summary off", d[7], 0);
    $display("test status registers done");
    // two beyond capacity: one overflow, one dropped
    push(22);
    acc(0, `SESR_ERR_COUNT, 0); chk("queue count", d, 20);
    for (int k = 1; k <= 19; k++) begin
      acc(0, `SESR_ERR_READ, 0); chk("queue entry", d, {16'(k), 16'(k)});
    end
    acc(0, `SESR_ERR_READ, 0); chk("overflow entry", d, {`SESR_ERR_OVERFLOW, `SESR_MSG_OVERFLOW});
    acc(0, `SESR_ERR_READ, 0); chk("empty queue", d, {`SESR_ERR_NONE, `SESR_MSG_NONE});
    push(2);
    acc(1, `SESR_CONTROL, 32'h0000_0002);
    acc(0, `SESR_ERR_COUNT, 0); chk("cleared queue", d, 0);
    $display("test error queue done");
    fail_num <= 7'h05;
    acc(1, `SESR_TEST_CMD, {1'b0, 15'h0003, 9'h000, 7'h05});
    wait_idle();
    acc(0, `SESR_TEST_STAT, 0); chk("repeat fails", d, {15'h0003, 17'h0_0000});
    acc(1, `SESR_TEST_CMD, {1'b0, 15'h0001, 9'h000, 7'h5f});
    acc(0, `SESR_TEST_STAT, 0); chk("refused test", d[0], 0);
    fail_num <= 7'h07;
    acc(1, `SESR_TEST_CMD, 32'h0000_0001);
    wait_idle();
    acc(0, `SESR_TEST_FIRST, 0); chk("first fail", d, 32'h0000_0007);
    acc(0, `SESR_FAIL_LIST, 0); chk("fail list", d, 32'h0000_0080);
    acc(0, `SESR_TEST_CODE, 32'h0000_0007); chk("fail code", d, 32'h0000_0007);
    acc(0, `SESR_TEST_DETAIL, 32'h0000_0007); chk("fail detail", d, 32'h0000_0007);
    $display("test self test done");
    close_out();
  end
endmodule
bind sesr_top sesr_checker #(.NBITS(NBITS), .NTEST(NTEST)) i_chk (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ques_cond_in(ques_cond_in), .status_byte(status_byte),
  .tst_start(tst_start), .tst_num(tst_num), .tst_busy(tst_busy));
